// File: src/sar_ctrl_pkg.sv
package sar_ctrl_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_STATE = 8'h14;

    // Control register bits
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BURST_BIT = 1;
    localparam int CTRL_START_BIT = 2;

    // Status and mask bits
    localparam int STAT_W = 2;
    localparam int STAT_EOC = 0;
    localparam int STAT_LOST = 1;

    // Configuration register, low bits first from tk upward
    typedef struct packed {
        logic [5:0] chan;
        logic [4:0] sar_div;
        logic [1:0] rpt;
        logic [1:0] tm;
        logic [1:0] tk;
    } cfg_t;
    localparam int CFG_W = 17;
    localparam cfg_t CFG_RST = '{chan: 6'h00, sar_div: 5'h1F, rpt: 2'h0, tm: 2'h3, tk: 2'h3};
    localparam logic [5:0] MUX_SEL_MAX = 6'h20;

    // Tracking modes
    localparam logic [1:0] TM_POST = 2'h1;
    localparam logic [1:0] TM_PRE = 2'h2;
    localparam logic [1:0] TM_DUAL = 2'h3;

    // Timing counts
    localparam logic [4:0] CONV_SAR_CYCLES = 5'h0D;
    localparam int SAR_BITS = 12;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TRK_A = 3'b001,
        ST_TRK_B = 3'b010,
        ST_TRK = 3'b011,
        ST_CSTART = 3'b100,
        ST_CONV = 3'b101,
        ST_CDONE = 3'b110
    } state_t;
endpackage

// File: src/sar_ctrl.sv
`timescale 1ns/10ps
module sar_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog side
    input wire logic cmp_in,
    input wire logic conv_start_pin,
    output logic conv_power,
    output logic track_connect,
    output logic conv_active,
    output logic [5:0] mux_sel,
    output logic [11:0] dac_code,
    // Interrupt
    output logic irq
);
    import sar_ctrl_pkg::*;

    function automatic logic [4:0] trk_sars(input logic [1:0] tk);
        trk_sars = 5'h02 << tk;
    endfunction

    function automatic logic [4:0] rpt_count(input logic [1:0] rpt);
        rpt_count = (rpt == 2'h0) ? 5'h01 : (5'h02 << rpt);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ADDR_CTRL) || (a == ADDR_CFG) || (a == ADDR_STAT)
            || (a == ADDR_MASK) || (a == ADDR_RESULT) || (a == ADDR_STATE);
    endfunction

    logic en_r, burst_r, burst_act_r;
    cfg_t cfg_r;
    logic [STAT_W-1:0] stat_r, mask_r;
    logic [15:0] acc_r, result_r;
    logic [3:0] rep_r;
    state_t state_r, state_nxt;
    logic [4:0] div_r, cnt_r;
    logic [11:0] dac_r, bit_r;
    logic cmp_s1_r, cmp_s2_r, pin_s1_r, pin_s2_r, pin_d_r;
    logic [31:0] prdata_r;
    logic err_r, track_r, active_r;
    logic setup, wr, start_req, start_ok, powered, sar_tick, last, is_pre;
    logic [STAT_W-1:0] stat_set;
    logic [15:0] sum;

    // Pin synchronisers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_d_r <= 1'b0;
        end else begin
            cmp_s1_r <= cmp_in;
            cmp_s2_r <= cmp_s1_r;
            pin_s1_r <= conv_start_pin;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_r;
    assign prdata = prdata_r;

    // Read data latched in setup phase
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else if (setup) begin
            err_r <= !is_mapped(paddr);
            case (paddr)
                ADDR_CTRL: prdata_r <= {30'h0, burst_r, en_r};
                ADDR_CFG: prdata_r <= {15'h0, cfg_r};
                ADDR_STAT: prdata_r <= {30'h0, stat_r};
                ADDR_MASK: prdata_r <= {30'h0, mask_r};
                ADDR_RESULT: prdata_r <= {16'h0, result_r};
                ADDR_STATE: prdata_r <= {22'h0, rep_r, burst_act_r, active_r,
                    track_r, state_r};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Control and configuration
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            en_r <= 1'b0;
            burst_r <= 1'b0;
            cfg_r <= CFG_RST;
            mask_r <= '0;
        end else if (wr) begin
            if (paddr == ADDR_CTRL) begin
                en_r <= pwdata[CTRL_EN_BIT];
                burst_r <= pwdata[CTRL_BURST_BIT];
            end
            if (paddr == ADDR_CFG) begin
                cfg_r <= cfg_t'(pwdata[CFG_W-1:0]);
                if (pwdata[CFG_W-1:CFG_W-6] > MUX_SEL_MAX) begin
                    cfg_r.chan <= MUX_SEL_MAX;
                end
            end
            if (paddr == ADDR_MASK) begin
                mask_r <= pwdata[STAT_W-1:0];
            end
        end
    end

    assign start_req = (wr && paddr == ADDR_CTRL && pwdata[CTRL_START_BIT])
        || (pin_s2_r && !pin_d_r);
    assign start_ok = start_req && state_r == ST_IDLE && (en_r || burst_r);
    assign powered = en_r || burst_act_r;
    assign is_pre = cfg_r.tm == TM_PRE;
    assign sar_tick = div_r == cfg_r.sar_div;
    assign last = {1'b0, rep_r} == rpt_count(cfg_r.rpt) - 5'h01;
    assign sum = acc_r + {4'h0, dac_r};

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = is_pre ? ST_CSTART : ST_TRK_A;
                end
            end
            ST_TRK_A: state_nxt = ST_TRK_B;
            ST_TRK_B: state_nxt = ST_TRK;
            ST_TRK: begin
                if (sar_tick && cnt_r == trk_sars(cfg_r.tk) - 5'h01) begin
                    state_nxt = ST_CSTART;
                end
            end
            ST_CSTART: state_nxt = ST_CONV;
            ST_CONV: begin
                if (sar_tick && cnt_r == CONV_SAR_CYCLES - 5'h01) begin
                    state_nxt = ST_CDONE;
                end
            end
            ST_CDONE: begin
                if (burst_r && !last) begin
                    state_nxt = is_pre ? ST_CSTART : ST_TRK_A;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // A burst start only powers up on the next cycle, when burst_act_r is set, so it must not be cancelled here
        if (!powered && !start_ok) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // SAR clock divider and SAR cycle counter
    always_ff @(posedge mclk) begin
        if (!rst_n || (state_r != ST_TRK && state_r != ST_CONV)) begin
            div_r <= 5'h00;
            cnt_r <= 5'h00;
        end else if (sar_tick) begin
            div_r <= 5'h00;
            cnt_r <= (state_nxt == state_r) ? cnt_r + 5'h01 : 5'h00;
        end else begin
            div_r <= div_r + 5'h01;
        end
    end

    // Burst power hold
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            burst_act_r <= 1'b0;
        end else if (start_ok && burst_r) begin
            burst_act_r <= 1'b1;
        end else if (state_r == ST_CDONE && last) begin
            burst_act_r <= 1'b0;
        end
    end

    // Successive approximation, one bit per SAR cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dac_r <= 12'h000;
            bit_r <= 12'h000;
        end else if (state_r == ST_CSTART) begin
            dac_r <= 12'h800;
            bit_r <= 12'h800;
        end else if (state_r == ST_CONV && sar_tick && bit_r != 12'h000) begin
            dac_r <= (cmp_s2_r ? dac_r : (dac_r & ~bit_r)) | (bit_r >> 1);
            bit_r <= bit_r >> 1;
        end
    end

    // Accumulator
    always_ff @(posedge mclk) begin
        if (!rst_n || !powered) begin
            acc_r <= 16'h0000;
            rep_r <= 4'h0;
        end else if (state_r == ST_CDONE) begin
            acc_r <= last ? 16'h0000 : sum;
            rep_r <= last ? 4'h0 : rep_r + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_r <= 16'h0000;
        end else if (state_r == ST_CDONE && last) begin
            result_r <= sum;
        end
    end

    // Sticky status, set beats clear
    always_comb begin
        stat_set = '0;
        stat_set[STAT_EOC] = state_r == ST_CDONE && last;
        stat_set[STAT_LOST] = start_req && state_r != ST_IDLE;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stat_r <= '0;
        end else if (wr && paddr == ADDR_STAT) begin
            stat_r <= (stat_r & ~pwdata[STAT_W-1:0]) | stat_set;
        end else begin
            stat_r <= stat_r | stat_set;
        end
    end

    assign irq = |(stat_r & mask_r);

    // Sampling switch and conversion indicator
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            track_r <= 1'b0;
            active_r <= 1'b0;
        end else begin
            active_r <= state_nxt inside {ST_CSTART, ST_CONV, ST_CDONE};
            case (state_nxt)
                ST_TRK_A, ST_TRK_B, ST_TRK: track_r <= 1'b1;
                ST_IDLE: track_r <= powered && (is_pre || cfg_r.tm == TM_DUAL);
                default: track_r <= 1'b0;
            endcase
        end
    end

    assign conv_power = powered;
    assign track_connect = track_r;
    assign conv_active = active_r;
    assign mux_sel = cfg_r.chan;
    assign dac_code = dac_r;

    // Helper cycle counter for tracking and conversion lengths
    logic [9:0] ph_cyc_r;
    always_ff @(posedge mclk) begin
        if (!rst_n || state_nxt != state_r) begin
            ph_cyc_r <= 10'h000;
        end else begin
            ph_cyc_r <= ph_cyc_r + 10'h001;
        end
    end

    a_enable_power: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && paddr == ADDR_CTRL && pwdata[CTRL_EN_BIT] |=> conv_power)
        else $error("enable did not power converter");
    a_off_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        !conv_power && !start_ok |=> state_r == ST_IDLE) else $error("unpowered but busy");
    a_burst_off: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_CDONE && last && !en_r && burst_act_r |=> !conv_power)
        else $error("burst did not shut down");
    a_post_start: assert property (@(posedge mclk) disable iff (!rst_n)
        start_ok && !is_pre |=> state_r == ST_TRK_A ##1 state_r == ST_TRK_B ##1 track_connect)
        else $error("tracking did not start on convert start");
    a_pre_start: assert property (@(posedge mclk) disable iff (!rst_n)
        start_ok && is_pre |=> state_r == ST_CSTART ##1 state_r == ST_CONV)
        else $error("pre-tracking conversion did not start at once");
    a_trk_len: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_TRK && state_nxt == ST_CSTART |->
        ph_cyc_r == 10'(trk_sars(cfg_r.tk)) * (10'(cfg_r.sar_div) + 10'h001) - 10'h001)
        else $error("tracking window length wrong");
    a_conv_len: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_CONV && state_nxt == ST_CDONE |->
        ph_cyc_r == 10'(CONV_SAR_CYCLES) * (10'(cfg_r.sar_div) + 10'h001) - 10'h001)
        else $error("conversion length wrong");
    a_post_hiz: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_r.tm == TM_POST && $stable(cfg_r.tm) && state_r == ST_IDLE
        && $past(state_r) == ST_IDLE |-> !track_connect)
        else $error("post-tracking input not disconnected");
    a_dual_track: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_r.tm == TM_DUAL && $stable(cfg_r.tm) && $past(state_r) == ST_CDONE
        && state_r == ST_IDLE && conv_power |-> track_connect)
        else $error("dual-tracking not tracking after conversion");
    a_eoc_set: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_CDONE && last |=> stat_r[STAT_EOC] && result_r == $past(sum))
        else $error("end of conversion not flagged");
    a_rep_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        {1'b0, rep_r} < rpt_count(cfg_r.rpt) || $changed(cfg_r.rpt))
        else $error("repeat counter overran");
endmodule

// File: verification/sar_analog.sv
`timescale 1ns/10ps
module sar_analog (
    // Converter side
    input wire logic mclk,
    input wire logic [5:0] mux_sel,
    input wire logic [11:0] dac_code,
    input wire logic track_connect,
    output logic cmp_in
);
    logic [11:0] hold_r = 12'h000;
    // Capacitor follows the input only while the switch is closed
    always @(posedge mclk) begin
        if (track_connect)
            hold_r <= 12'(mux_sel * 123 + 341);
    end
    assign cmp_in = hold_r >= dac_code;
endmodule

// File: verification/sar_ctrl_bench.sv
`timescale 1ns/10ps
module sar_ctrl_bench;
    import sar_ctrl_pkg::*;
    logic mclk = 0;
    logic rst_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic conv_start_pin = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic [11:0] dac_code;
    logic [5:0] mux_sel;
    logic pready, pslverr, cmp_in, conv_power, track_connect, conv_active, irq, err;
    int n_mismatch = 0;
    int checks = 0;
    int seed = 68;
    int lat, dur, ch, r, k;
    logic [1:0] tms [7] = '{2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3};
    logic [1:0] tks [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3};

    initial begin
        forever #5 mclk = ~mclk;
    end

    sar_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in),
        .conv_start_pin(conv_start_pin), .conv_power(conv_power),
        .track_connect(track_connect), .conv_active(conv_active),
        .mux_sel(mux_sel), .dac_code(dac_code), .irq(irq));
    sar_analog u_far (.mclk(mclk), .mux_sel(mux_sel), .dac_code(dac_code),
        .track_connect(track_connect), .cmp_in(cmp_in));

    function automatic int volt(input int c);
        return (c * 123 + 341) % 4096;
    endfunction

    task automatic results();
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic hang(input int i, input int lim);
        if (i >= lim) begin
            n_mismatch++;
            results();
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        hang(i, 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, ADDR_STAT, 32'h0);
            if (q[STAT_EOC] === 1'b1)
                break;
        end
        hang(i, 400);
    endtask

    task automatic measure();
        lat = 0;
        dur = 0;
        // Let the start edge's register updates settle first
        #1;
        while (lat < 300 && conv_active !== 1'b1) begin
            @(posedge mclk);
            #1;
            lat++;
        end
        while (dur < 300 && conv_active === 1'b1) begin
            @(posedge mclk);
            #1;
            dur++;
        end
        hang(lat + dur, 300);
    endtask

    task automatic run(input logic [1:0] tm, input logic [1:0] tk, input int c);
        apb(1'b1, ADDR_CFG, {15'h0, c[5:0], 5'h03, 2'h0, tm, tk});
        apb(1'b1, ADDR_CTRL, 32'h5);
        measure();
        if (tm == TM_PRE)
            chk("pre_lat", 0, lat);
        else
            chk("trk_lat", 2 + (2 << tk) * 4, lat);
        chk("conv_len", 13 * 4 + 2, dur);
        wait_done();
        chk("stat", 32'h1, q);
        chk("irq", 1, irq);
        apb(1'b0, ADDR_RESULT, 32'h0);
        chk("result", volt(c), q);
        if (tm == TM_POST)
            chk("trk_post", 0, track_connect);
        if (tm == TM_DUAL)
            chk("trk_dual", 1, track_connect);
        apb(1'b1, ADDR_STAT, 32'h1);
        #1;
        chk("irq_clr", 0, irq);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_CFG, 32'h0);
        chk("cfg_rst", {15'h0, CFG_RST}, q);
        chk("pwr_rst", 0, conv_power);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmap_err", 1, err);
        chk("unmap_dat", 0, q);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_MASK, 32'h3);
        chk("pwr_en", 1, conv_power);
        for (k = 0; k < 7; k++) begin
            ch = $unsigned($random(seed)) % 33;
            run(tms[k], tks[k], ch);
        end
        apb(1'b1, ADDR_CTRL, 32'h5);
        apb(1'b1, ADDR_CTRL, 32'h5);
        wait_done();
        chk("stat_lost", 32'h3, q);
        apb(1'b1, ADDR_STAT, 32'h3);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("stat_w1c", 32'h0, q);
        ch = $unsigned($random(seed)) % 33;
        apb(1'b1, ADDR_CFG, {15'h0, 6'(ch), 5'h03, 6'h08});
        conv_start_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        conv_start_pin <= 1'b0;
        wait_done();
        apb(1'b0, ADDR_RESULT, 32'h0);
        chk("pin_result", volt(ch), q);
        apb(1'b1, ADDR_STAT, 32'h3);
        for (r = 1; r < 4; r++) begin
            ch = $unsigned($random(seed)) % 33;
            apb(1'b1, ADDR_CTRL, 32'h2);
            apb(1'b1, ADDR_MASK, 32'h0);
            apb(1'b1, ADDR_CFG, {15'h0, 6'(ch), 5'h03, 2'(r), 4'hC});
            chk("pwr_off", 0, conv_power);
            apb(1'b1, ADDR_CTRL, 32'h6);
            @(posedge mclk);
            #1;
            chk("pwr_burst", 1, conv_power);
            wait_done();
            apb(1'b0, ADDR_RESULT, 32'h0);
            chk("acc_sum", (2 << r) * volt(ch), q);
            chk("pwr_after", 0, conv_power);
            chk("irq_mask", 0, irq);
            apb(1'b1, ADDR_STAT, 32'h3);
        end
        apb(1'b1, ADDR_CFG, {15'h0, 6'h3F, 5'h03, 6'h0C});
        apb(1'b0, ADDR_CFG, 32'h0);
        chk("chan_max", {26'h0, MUX_SEL_MAX}, {26'h0, q[16:11]});
        chk("mux_sel", {26'h0, MUX_SEL_MAX}, {26'h0, mux_sel});
        results();
    end
endmodule
